// ### src/ashi_pkg.sv
package ashi_pkg;
  // register select codes carried in the low nibble of the command byte
  localparam logic [3:0]  REG_STAT      = 4'h0;
  localparam logic [3:0]  REG_CFG       = 4'h2;
  localparam logic [3:0]  REG_FILT      = 4'h3;
  localparam logic [3:0]  REG_DATA      = 4'h4;
  localparam int          CMD_RW_BIT    = 6;
  localparam int          STAT_RDY_BIT  = 7;
  localparam int          CFG_CH_LSB    = 0;
  localparam int          W_BYTE        = 8;
  localparam int          W_DATA        = 16;
  localparam int          W_CFG         = 24;
  localparam logic [4:0]  LAST_BYTE     = 5'h07;
  localparam logic [4:0]  LAST_DATA     = 5'h0F;
  localparam logic [4:0]  LAST_CFG      = 5'h17;
  localparam logic [23:0] CFG_RST       = 24'h000000;
  localparam logic [7:0]  FILT_RST      = 8'h45;
  localparam logic [7:0]  SF_MIN        = 8'h0D;
  localparam logic [5:0]  ONES_LAST     = 6'h1F;
  localparam logic [1:0]  SETTLE_CONV   = 2'h3;
  // output period is the filter word, raised to SF_MIN if below it, times one rate unit
  localparam int          T_PERIOD_MAX_US = 186770;
  localparam int          SF_FULL         = 255;
  localparam int          SYS_MHZ         = 250;
  localparam int          UNIT_CYC_DEF    = (T_PERIOD_MAX_US * SYS_MHZ) / SF_FULL;
  // input pair codes; 3'h4 is the common input
  localparam logic [2:0]  AIN_1   = 3'h0;
  localparam logic [2:0]  AIN_2   = 3'h1;
  localparam logic [2:0]  AIN_3   = 3'h2;
  localparam logic [2:0]  AIN_4   = 3'h3;
  localparam logic [2:0]  AIN_COM = 3'h4;
  typedef enum logic [2:0] {
    ST_COMM  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } ashi_lnk_st_t;
endpackage

// ### src/ashi_sync.sv
`timescale 1ns/1ps
module ashi_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // ashi_sync

// ### src/ashi_top.sv
`timescale 1ns/1ps
module ashi_top #(
  parameter int UNIT_CYC = ashi_pkg::UNIT_CYC_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             rdy_n,
  input  wire logic [15:0] filt_result,
  output logic [2:0]       ain_pos_sel,
  output logic [2:0]       ain_neg_sel
);
  localparam logic [17:0] UNIT_LAST = 18'(UNIT_CYC - 1);

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic lrst_n, cfg_s, rdd_s, upd_s;
  logic cfg_tgl_r, cfg_tgl_nxt, rdd_tgl_r, rdd_tgl_nxt, upd_tgl_r, upd_tgl_nxt;
  // the link side only leaves reset once the serial clock has ticked twice
  ashi_sync u_lrst (.clk(sclk), .rst_n(1'b1), .d(reset_n), .q(lrst_n));
  ashi_sync u_cfg (.clk(sys_clk), .rst_n(reset_n), .d(cfg_tgl_r), .q(cfg_s));
  ashi_sync u_rdd (.clk(sys_clk), .rst_n(reset_n), .d(rdd_tgl_r), .q(rdd_s));
  ashi_sync u_upd (.clk(sclk), .rst_n(lrst_n), .d(upd_tgl_r), .q(upd_s));

  // ----------------------------------------------------------------
  // link side, rising serial clock
  // ----------------------------------------------------------------
  ashi_pkg::ashi_lnk_st_t st_r, st_nxt;
  logic [4:0]  bit_r, bit_nxt, last_r, last_nxt;
  logic [5:0]  ones_r, ones_nxt;
  logic [3:0]  addr_r, addr_nxt;
  logic [23:0] sh_r, sh_nxt, rd_sh_r, rd_sh_nxt, cfg_lnk_r, cfg_lnk_nxt;
  logic [7:0]  filt_lnk_r, filt_lnk_nxt, cmd;
  logic [15:0] data_lnk_r, data_lnk_nxt, data_sys_r;
  logic        rdy_lnk_r, rdy_lnk_nxt, upd_q_r, upd_evt_l, ones_hit;
  logic [23:0] wr_word;

  always_comb begin
    st_nxt       = st_r;
    bit_nxt      = bit_r;
    last_nxt     = last_r;
    ones_nxt     = ones_r;
    addr_nxt     = addr_r;
    sh_nxt       = sh_r;
    rd_sh_nxt    = rd_sh_r;
    cfg_lnk_nxt  = cfg_lnk_r;
    filt_lnk_nxt = filt_lnk_r;
    cfg_tgl_nxt  = cfg_tgl_r;
    rdd_tgl_nxt  = rdd_tgl_r;
    cmd          = {sh_r[6:0], sdi};
    wr_word      = {sh_r[22:0], sdi};
    upd_evt_l    = upd_s ^ upd_q_r;
    ones_hit     = 1'b0;
    // data word is stable long before its toggle arrives
    data_lnk_nxt = upd_evt_l ? data_sys_r : data_lnk_r;
    rdy_lnk_nxt  = rdy_lnk_r;
    if (!cs_n) begin
      if (st_r != ashi_pkg::ST_READ) begin
        ones_nxt = sdi ? ones_r + 6'h01 : 6'h00;
        ones_hit = sdi && (ones_r == ashi_pkg::ONES_LAST);
      end
      case (st_r)
        ashi_pkg::ST_COMM: begin
          sh_nxt  = wr_word;
          bit_nxt = bit_r + 5'h01;
          if (bit_r == ashi_pkg::LAST_BYTE) begin
            bit_nxt  = 5'h00;
            addr_nxt = cmd[3:0];
            last_nxt = ashi_pkg::LAST_BYTE;
            if (cmd[ashi_pkg::CMD_RW_BIT]) begin
              st_nxt = ashi_pkg::ST_READ;
              case (cmd[3:0])
                ashi_pkg::REG_STAT:
                  rd_sh_nxt = {rdy_lnk_r, 7'h00, 16'h0000};
                ashi_pkg::REG_CFG: begin
                  rd_sh_nxt = cfg_lnk_r;
                  last_nxt  = ashi_pkg::LAST_CFG;
                end
                ashi_pkg::REG_FILT: rd_sh_nxt = {filt_lnk_r, 16'h0000};
                ashi_pkg::REG_DATA: begin
                  rd_sh_nxt = {data_lnk_r, 8'h00};
                  last_nxt  = ashi_pkg::LAST_DATA;
                end
                default: rd_sh_nxt = 24'h000000;
              endcase
            end else if (cmd[3:0] == ashi_pkg::REG_CFG) begin
              st_nxt   = ashi_pkg::ST_WRITE;
              last_nxt = ashi_pkg::LAST_CFG;
            end else if (cmd[3:0] == ashi_pkg::REG_FILT) begin
              st_nxt = ashi_pkg::ST_WRITE;
            end
          end
        end
        ashi_pkg::ST_WRITE: begin
          sh_nxt  = wr_word;
          bit_nxt = bit_r + 5'h01;
          if (bit_r == last_r) begin
            bit_nxt     = 5'h00;
            st_nxt      = ashi_pkg::ST_COMM;
            cfg_tgl_nxt = ~cfg_tgl_r;
            if (addr_r == ashi_pkg::REG_CFG) cfg_lnk_nxt = wr_word;
            else filt_lnk_nxt = wr_word[7:0];
          end
        end
        ashi_pkg::ST_READ: begin
          // sdi never reaches any register here
          rd_sh_nxt = {rd_sh_r[22:0], 1'b0};
          bit_nxt   = bit_r + 5'h01;
          if (bit_r == last_r) begin
            bit_nxt = 5'h00;
            st_nxt  = ashi_pkg::ST_COMM;
            if (addr_r == ashi_pkg::REG_DATA) begin
              rdd_tgl_nxt = ~rdd_tgl_r;
              rdy_lnk_nxt = 1'b0;
            end
          end
        end
        default: st_nxt = ashi_pkg::ST_COMM;
      endcase
      if (ones_hit) begin
        st_nxt       = ashi_pkg::ST_COMM;
        bit_nxt      = 5'h00;
        ones_nxt     = 6'h00;
        cfg_lnk_nxt  = ashi_pkg::CFG_RST;
        filt_lnk_nxt = ashi_pkg::FILT_RST;
        cfg_tgl_nxt  = ~cfg_tgl_r;
        rdy_lnk_nxt  = 1'b0;
      end
    end
    if (upd_evt_l) rdy_lnk_nxt = 1'b1; // set wins over the read clear
  end

  always_ff @(posedge sclk) begin
    if (!lrst_n) begin
      st_r       <= ashi_pkg::ST_COMM;
      bit_r      <= 5'h00;
      last_r     <= ashi_pkg::LAST_BYTE;
      ones_r     <= 6'h00;
      addr_r     <= 4'h0;
      sh_r       <= 24'h000000;
      rd_sh_r    <= 24'h000000;
      cfg_lnk_r  <= ashi_pkg::CFG_RST;
      filt_lnk_r <= ashi_pkg::FILT_RST;
      cfg_tgl_r  <= 1'b0;
      rdd_tgl_r  <= 1'b0;
      data_lnk_r <= 16'h0000;
      rdy_lnk_r  <= 1'b0;
      upd_q_r    <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      bit_r      <= bit_nxt;
      last_r     <= last_nxt;
      ones_r     <= ones_nxt;
      addr_r     <= addr_nxt;
      sh_r       <= sh_nxt;
      rd_sh_r    <= rd_sh_nxt;
      cfg_lnk_r  <= cfg_lnk_nxt;
      filt_lnk_r <= filt_lnk_nxt;
      cfg_tgl_r  <= cfg_tgl_nxt;
      rdd_tgl_r  <= rdd_tgl_nxt;
      data_lnk_r <= data_lnk_nxt;
      rdy_lnk_r  <= rdy_lnk_nxt;
      upd_q_r    <= upd_s;
    end
  end

  // ----------------------------------------------------------------
  // link side, falling serial clock: data output
  // ----------------------------------------------------------------
  logic sdo_nxt, sdo_oe_nxt;
  always_comb begin
    // drive only during a selected read, leave the pull-up otherwise
    sdo_oe_nxt = (st_r == ashi_pkg::ST_READ) && !cs_n;
    sdo_nxt    = sdo_oe_nxt && rd_sh_r[23];
  end
  always_ff @(negedge sclk) begin
    if (!lrst_n) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= sdo_nxt;
      sdo_oe <= sdo_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // conversion timing, system clock
  // ----------------------------------------------------------------
  logic [17:0] unit_r, unit_nxt;
  logic [7:0]  sf_cnt_r, sf_cnt_nxt, sf_r, sf_nxt;
  logic [2:0]  chan_r, chan_nxt, pos_nxt, neg_nxt, new_chan;
  logic [1:0]  settle_r, settle_nxt;
  logic [15:0] data_sys_nxt;
  logic        cfg_q_r, rdd_q_r, rdy_n_nxt, cfg_evt, rdd_evt, pre_upd, per_end;

  always_comb begin
    unit_nxt     = unit_r + 18'h00001;
    sf_cnt_nxt   = sf_cnt_r;
    sf_nxt       = sf_r;
    chan_nxt     = chan_r;
    settle_nxt   = settle_r;
    data_sys_nxt = data_sys_r;
    upd_tgl_nxt  = upd_tgl_r;
    rdy_n_nxt    = rdy_n;
    cfg_evt      = cfg_s ^ cfg_q_r;
    rdd_evt      = rdd_s ^ rdd_q_r;
    new_chan     = cfg_lnk_r[ashi_pkg::CFG_CH_LSB +: 3];
    pre_upd      = (sf_cnt_r == sf_r - 8'h01) && (unit_r == 18'h00000);
    per_end      = (sf_cnt_r == sf_r - 8'h01) && (unit_r == UNIT_LAST);
    if (unit_r == UNIT_LAST) begin
      unit_nxt   = 18'h00000;
      sf_cnt_nxt = per_end ? 8'h00 : sf_cnt_r + 8'h01;
    end
    if (rdd_evt) rdy_n_nxt = 1'b1;
    if (pre_upd) rdy_n_nxt = 1'b1; // warn before the word changes
    if (per_end) begin
      if (settle_r != 2'h0) begin
        settle_nxt = settle_r - 2'h1;
      end else begin
        data_sys_nxt = filt_result;
        upd_tgl_nxt  = ~upd_tgl_r;
        rdy_n_nxt    = 1'b0;
      end
    end
    if (cfg_evt) begin
      // words on the link side are frozen until the next write completes or a run of ones resets them
      sf_nxt = (filt_lnk_r < ashi_pkg::SF_MIN) ? ashi_pkg::SF_MIN : filt_lnk_r;
      if (new_chan != chan_r) begin
        chan_nxt   = new_chan;
        settle_nxt = ashi_pkg::SETTLE_CONV;
        unit_nxt   = 18'h00000;
        sf_cnt_nxt = 8'h00;
        rdy_n_nxt  = 1'b1;
      end
    end
    case (chan_r[2:1])
      2'b10: begin pos_nxt = ashi_pkg::AIN_1 | {1'b0, chan_r[0], 1'b0}; end
      2'b11: begin pos_nxt = ashi_pkg::AIN_2 | {1'b0, chan_r[0], 1'b0}; end
      default: begin pos_nxt = chan_r[0] ? ashi_pkg::AIN_3 : ashi_pkg::AIN_1; end
    endcase
    case (chan_r[2])
      1'b1: neg_nxt = ashi_pkg::AIN_COM;
      default: neg_nxt = chan_r[0] ? ashi_pkg::AIN_4 : ashi_pkg::AIN_2;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      unit_r      <= 18'h00000;
      sf_cnt_r    <= 8'h00;
      sf_r        <= ashi_pkg::FILT_RST;
      chan_r      <= ashi_pkg::CFG_RST[2:0];
      settle_r    <= ashi_pkg::SETTLE_CONV;
      data_sys_r  <= 16'h0000;
      upd_tgl_r   <= 1'b0;
      rdy_n       <= 1'b1;
      cfg_q_r     <= 1'b0;
      rdd_q_r     <= 1'b0;
      ain_pos_sel <= ashi_pkg::AIN_1;
      ain_neg_sel <= ashi_pkg::AIN_2;
    end else begin
      unit_r      <= unit_nxt;
      sf_cnt_r    <= sf_cnt_nxt;
      sf_r        <= sf_nxt;
      chan_r      <= chan_nxt;
      settle_r    <= settle_nxt;
      data_sys_r  <= data_sys_nxt;
      upd_tgl_r   <= upd_tgl_nxt;
      rdy_n       <= rdy_n_nxt;
      cfg_q_r     <= cfg_s;
      rdd_q_r     <= rdd_s;
      ain_pos_sel <= pos_nxt;
      ain_neg_sel <= neg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_wr_quiet;
    @(posedge sclk) disable iff (!lrst_n)
      (st_r == ashi_pkg::ST_WRITE) && $past(st_r == ashi_pkg::ST_WRITE) |-> !sdo_oe && !sdo;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("output driven during write");
  property p_rd_ignore;
    @(posedge sclk) disable iff (!lrst_n)
      (st_r == ashi_pkg::ST_READ) && !ones_hit |=> $stable(cfg_lnk_r) && $stable(filt_lnk_r);
  endproperty
  a_rd_ignore: assert property (p_rd_ignore) else $error("input taken during read");
  property p_msb_first;
    @(posedge sclk) disable iff (!lrst_n)
      (st_r == ashi_pkg::ST_READ) && sdo_oe |-> sdo == rd_sh_r[23];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read bit order wrong");
  property p_cmd_read;
    @(posedge sclk) disable iff (!lrst_n)
      !cs_n && (st_r == ashi_pkg::ST_COMM) && (bit_r == ashi_pkg::LAST_BYTE) &&
      cmd[ashi_pkg::CMD_RW_BIT] && !ones_hit |=> (st_r == ashi_pkg::ST_READ) && (bit_r == 5'h00);
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command byte not decoded");
  property p_ones_reset;
    @(posedge sclk) disable iff (!lrst_n)
      ones_hit |=> (st_r == ashi_pkg::ST_COMM) && (cfg_lnk_r == ashi_pkg::CFG_RST) &&
      (filt_lnk_r == ashi_pkg::FILT_RST);
  endproperty
  a_ones_reset: assert property (p_ones_reset) else $error("ones reset missed");
  property p_stat_set;
    @(posedge sclk) disable iff (!lrst_n)
      upd_evt_l |=> rdy_lnk_r && (data_lnk_r == $past(data_sys_r));
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status ready not set");
  property p_rdy_fall;
    @(posedge sys_clk) disable iff (!reset_n)
      per_end && (settle_r == 2'h0) && !cfg_evt |=>
        !rdy_n ##1 (!rdy_n || $past(rdd_evt || pre_upd || cfg_evt));
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready line did not fall");
  property p_rdy_rise;
    @(posedge sys_clk) disable iff (!reset_n)
      (rdd_evt || pre_upd) && !per_end |=> rdy_n;
  endproperty
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready line did not rise");
  property p_settle;
    @(posedge sys_clk) disable iff (!reset_n)
      per_end && (settle_r != 2'h0) && !cfg_evt |=> $stable(data_sys_r) && $stable(upd_tgl_r);
  endproperty
  a_settle: assert property (p_settle) else $error("result flagged while settling");
  property p_rate;
    @(posedge sys_clk) disable iff (!reset_n)
      sf_r >= ashi_pkg::SF_MIN;
  endproperty
  a_rate: assert property (p_rate) else $error("output rate above limit");
  property p_pseudo;
    @(posedge sys_clk) disable iff (!reset_n)
      chan_r[2] |=> ain_neg_sel == ashi_pkg::AIN_COM;
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo pair not on common");
endmodule // ashi_top

// ### test/ashi_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// serial host: clock idles high and runs inside frames and, deselected, in the idle task
// ----------------------------------------------------------
module ashi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      host_oe,
  output logic      host_bit,
  input  wire logic data_line,
  input  wire logic sdo_oe
);
  logic host_tx_frame_sync_n;
  logic host_rx_frame_sync_n;
  int   n_clash;

  assign cs_n = host_tx_frame_sync_n & host_rx_frame_sync_n;

  initial begin
    sclk                 = 1'b1;
    host_tx_frame_sync_n = 1'b1;
    host_rx_frame_sync_n = 1'b1;
    host_oe              = 1'b0;
    host_bit             = 1'b0;
    n_clash              = 0;
  end

  // both ends driving the shared line at a sample would corrupt the bit
  always @(posedge sclk) begin
    if (host_oe && sdo_oe) begin
      n_clash++;
    end
  end

  // deselected clocks, only so the link side can leave reset
  task automatic idle(input int n);
    repeat (n) begin
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
  endtask

  // nw bits written msb first, then nr bits read with the line released
  // 80 ns bit time is a bench speed-up; a frame-synced host in a system stays at 3 MHz
  task automatic frame(input int nw, input logic [39:0] wv, input int nr,
                       output logic [23:0] rv);
    rv = 24'h000000;
    #1.3;
    for (int i = 0; i < nw + nr; i++) begin
      host_tx_frame_sync_n = (i < nw) ? 1'b0 : 1'b1;
      host_rx_frame_sync_n = (i < nw) ? 1'b1 : 1'b0;
      host_oe              = (i < nw);
      host_bit             = (i < nw) ? wv[nw-1-i] : 1'b0;
      #20 sclk = 1'b0;
      #40 sclk = 1'b1;
      if (i >= nw) begin
        rv = {rv[22:0], data_line};
      end
      #20;
    end
    host_tx_frame_sync_n = 1'b1;
    host_rx_frame_sync_n = 1'b1;
    host_oe              = 1'b0;
  endtask
endmodule // ashi_host_model

// ### test/ashi_top_tb.sv
`timescale 1ns/1ps
module ashi_top_tb;
  localparam int UC = 20;
  logic        sys_clk;
  logic        reset_n;
  logic [15:0] filt_result;
  logic        junk_en;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        rdy_n;
  logic [2:0]  ain_pos_sel;
  logic [2:0]  ain_neg_sel;
  logic        host_oe;
  logic        host_bit;
  tri1         data_line;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc    = 0;
  logic [23:0] v;
  int          t0;
  int          t1;
  int          t2;
  logic [7:0]  sf [3];

  // ----------------------------
  // clock and shared data line
  // ----------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  assign data_line = sdo_oe ? sdo : 1'bz;
  assign data_line = host_oe ? host_bit : 1'bz;
  // junk_en stands for a separate input wire held at one during reads
  assign sdi = (junk_en && sdo_oe) ? 1'b1 : data_line;

  ashi_top #(.UNIT_CYC(UC)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .rdy_n(rdy_n),
    .filt_result(filt_result), .ain_pos_sel(ain_pos_sel),
    .ain_neg_sel(ain_neg_sel));

  ashi_host_model host (
    .sclk(sclk), .cs_n(cs_n), .host_oe(host_oe), .host_bit(host_bit),
    .data_line(data_line), .sdo_oe(sdo_oe));

  // ----------------------------
  // tasks
  // ----------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] r, input int n, input logic [23:0] d);
    logic [23:0] rv;
    host.frame(8 + n, (40'(r) << n) | 40'(d), 0, rv);
  endtask

  task automatic rd(input logic [3:0] r, input int n, output logic [23:0] d);
    host.frame(8, 40'(r) | 40'(1 << ashi_pkg::CMD_RW_BIT), n, d);
  endtask

  task automatic wait_rdy(input logic lv, output int t);
    for (int i = 0; i < 12000 && rdy_n !== lv; i++) @(negedge sys_clk);
    t = cyc;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      stop_test();
    end
  end

  // ----------------------------
  // main sequence
  // ----------------------------
  initial begin
    reset_n     = 1'b0;
    filt_result = 16'h0000;
    junk_en     = 1'b0;
    sf          = '{8'h05, 8'h0D, 8'h80};
    repeat (5) @(posedge sys_clk);
    // link side reset chain only moves on serial clock edges
    host.idle(4);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    host.idle(4);
    @(negedge sys_clk);
    check(24'(rdy_n), 24'h000001);
    check(24'(ain_pos_sel), 24'(ashi_pkg::AIN_1));
    check(24'(ain_neg_sel), 24'(ashi_pkg::AIN_2));
    rd(ashi_pkg::REG_CFG, ashi_pkg::W_CFG, v);
    check(v, ashi_pkg::CFG_RST);
    rd(ashi_pkg::REG_FILT, ashi_pkg::W_BYTE, v);
    check(v, 24'(ashi_pkg::FILT_RST));
    foreach (sf[k]) begin
      wr(ashi_pkg::REG_FILT, ashi_pkg::W_BYTE, 24'(sf[k]));
      wait_rdy(1'b0, t0);
      wait_rdy(1'b1, t0);
      wait_rdy(1'b0, t0);
      wait_rdy(1'b1, t1);
      wait_rdy(1'b0, t2);
      check(24'(t2 - t0), 24'(UC * int'((sf[k] < ashi_pkg::SF_MIN) ?
            ashi_pkg::SF_MIN : sf[k])));
      check(24'((t2 - t1) >= UC - 1 && (t2 - t1) <= UC + 1), 24'h1);
    end
    @(posedge sys_clk);
    filt_result <= 16'hA53C;
    wait_rdy(1'b1, t0);
    wait_rdy(1'b0, t0);
    rd(ashi_pkg::REG_STAT, ashi_pkg::W_BYTE, v);
    check(24'(v[ashi_pkg::STAT_RDY_BIT]), 24'h000001);
    rd(ashi_pkg::REG_DATA, ashi_pkg::W_DATA, v);
    check(v, 24'h00A53C);
    repeat (10) @(negedge sys_clk);
    check(24'(rdy_n), 24'h000001);
    rd(ashi_pkg::REG_STAT, ashi_pkg::W_BYTE, v);
    check(24'(v[ashi_pkg::STAT_RDY_BIT]), 24'h000000);
    for (int c = 0; c < 8; c++) begin
      wr(ashi_pkg::REG_CFG, ashi_pkg::W_CFG, 24'(c) << ashi_pkg::CFG_CH_LSB);
      repeat (10) @(negedge sys_clk);
      check(24'(ain_pos_sel), c[2] ? {22'h0, c[0], c[1]} : {22'h0, c[0], 1'b0});
      check(24'(ain_neg_sel), c[2] ? 24'(ashi_pkg::AIN_COM) : {22'h0, c[0], 1'b1});
    end
    check(24'(rdy_n), 24'h000001);
    t0 = cyc;
    wait_rdy(1'b0, t1);
    check(24'((t1 - t0) > 3 * 128 * UC && (t1 - t0) <= 4 * 128 * UC), 24'h1);
    // configuration word sent as separate frames
    host.frame(8, 40'(ashi_pkg::REG_CFG), 0, v);
    host.frame(16, 40'h0000, 0, v);
    host.frame(8, 40'h05, 0, v);
    repeat (10) @(negedge sys_clk);
    check(24'(ain_pos_sel), 24'(ashi_pkg::AIN_3));
    @(posedge sys_clk);
    junk_en <= 1'b1;
    rd(ashi_pkg::REG_CFG, ashi_pkg::W_CFG, v);
    check(v, 24'h000005);
    @(posedge sys_clk);
    junk_en <= 1'b0;
    // eight more ones would make 32 if read-phase ones were counted
    host.frame(8, 40'hFF, 8, v);
    check(v, 24'h000000);
    rd(ashi_pkg::REG_CFG, ashi_pkg::W_CFG, v);
    check(v, 24'h000005);
    host.frame(40, {8'h02, 32'hFFFFFFFF}, 0, v);
    rd(ashi_pkg::REG_STAT, ashi_pkg::W_BYTE, v);
    check(24'(v[ashi_pkg::STAT_RDY_BIT]), 24'h000000);
    check(24'(ain_pos_sel), 24'(ashi_pkg::AIN_1));
    rd(ashi_pkg::REG_CFG, ashi_pkg::W_CFG, v);
    check(v, ashi_pkg::CFG_RST);
    rd(ashi_pkg::REG_FILT, ashi_pkg::W_BYTE, v);
    check(v, 24'(ashi_pkg::FILT_RST));
    check(24'(host.n_clash), 24'h000000);
    stop_test();
  end
endmodule // ashi_top_tb
